/* File: pkg/sfs_defines.svh */
// Purpose: Constants for the supply fault supervisor.
// Assumes: 50 MHz clock.
// Notes: Times in their own units, counts derived from them.
`ifndef SFS_DEFINES_SVH
`define SFS_DEFINES_SVH
`define SFS_CLK_MHZ 50
`define SFS_UV_FILT_NS 3500
`define SFS_CP_FILT_NS 4000
`define SFS_UV_FILT_CYC ((`SFS_UV_FILT_NS * `SFS_CLK_MHZ) / 1000)
`define SFS_CP_FILT_CYC ((`SFS_CP_FILT_NS * `SFS_CLK_MHZ) / 1000)
`define SFS_RESTART_MS 64
`define SFS_RESTART_CYC (`SFS_RESTART_MS * `SFS_CLK_MHZ * 1000)
`define SFS_NCH 5
`define SFS_A_QUICK 12'h004
`define SFS_A_DEVST 12'h01C
`define SFS_A_OUTCTL 12'h020
`define SFS_A_MODE 12'h024
`define SFS_A_IRQST 12'h028
`define SFS_A_IRQMSK 12'h02C
`define SFS_B_PUMP 0
`define SFS_B_UV 0
`define SFS_B_OV 1
`define SFS_B_SUM 7
`endif

/* File: pkg/sfs_pkg.sv */
// Purpose: Types for the supply fault supervisor.
// Assumes: Nothing.
// Notes: Event vector layout is shared by status and mask.
package sfs_pkg;
   typedef struct packed
   {
      logic pump;
      logic high;
      logic low;
   } sfs_evt_t;
   typedef enum logic [2:0]
   {
      SFS_RUN = 3'b001,
      SFS_OFF = 3'b010,
      SFS_WAIT = 3'b100
   } sfs_st_t;
endpackage : sfs_pkg

/* File: logic/sfs_filter.sv */
// Purpose: Deglitch filter for one fault level.
// Assumes: Input is synchronous.
// Notes: Counter restarts whenever the input drops.
`timescale 1ns/1ps
module sfs_filter #(
   parameter int CYCLES = 175
)(
   input wire logic clock_in,
   input wire logic sys_rst_in,
   input wire logic level_in,
   output logic hit_out
);
   typedef struct packed
   {
      logic [15:0] cnt;
      logic hit;
   } sfs_flt_t;
   sfs_flt_t st, next_st;
   always_comb
   begin
      next_st = st;
      if (!level_in)
      begin
         next_st.cnt = 16'h0000;
         next_st.hit = 1'b0;
      end
      else if (st.cnt >= 16'(CYCLES - 1))
      begin
         next_st.hit = 1'b1;
      end
      else
      begin
         next_st.cnt = st.cnt + 16'h0001;
      end
   end
   always_ff @(posedge clock_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
      begin
         st <= '0;
      end
      else
      begin
         st <= next_st;
      end
   end
   assign hit_out = st.hit;
endmodule : sfs_filter

/* File: logic/sfs_timer.sv */
// Purpose: Autorestart interval timer.
// Assumes: Run is a level; counts only while run held, clears when it drops.
// Notes: Done pulses for one cycle each time the interval elapses while run is held.
`timescale 1ns/1ps
module sfs_timer #(
   parameter int CYCLES = 3200000
)(
   input wire logic clock_in,
   input wire logic sys_rst_in,
   input wire logic run_in,
   output logic done_out
);
   typedef struct packed
   {
      logic [31:0] cnt;
      logic done;
   } sfs_tmr_t;
   sfs_tmr_t st, next_st;
   always_comb
   begin
      next_st = st;
      next_st.done = 1'b0;
      if (!run_in)
      begin
         next_st.cnt = 32'h0000_0000;
      end
      else if (st.cnt >= 32'(CYCLES - 1))
      begin
         next_st.cnt = 32'h0000_0000;
         next_st.done = 1'b1;
      end
      else
      begin
         next_st.cnt = st.cnt + 32'h0000_0001;
      end
   end
   always_ff @(posedge clock_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
      begin
         st <= '0;
      end
      else
      begin
         st <= next_st;
      end
   end
   assign done_out = st.done;
endmodule : sfs_timer

/* File: logic/sfs_top.sv */
// Purpose: Supply and charge pump supervisor for five power channels.
// Assumes: Fault levels arrive synchronous, hysteresis already applied.
// Notes: Registers on APB; zero wait states.
`timescale 1ns/1ps
`include "sfs_defines.svh"
module sfs_top #(
   parameter int RESTART_CYC = `SFS_RESTART_CYC,
   parameter int NCH = `SFS_NCH
)(
   input wire logic clock_in,
   input wire logic sys_rst_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [11:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   input wire logic supply_low_in,
   input wire logic supply_high_in,
   input wire logic pump_valid_in,
   output logic [NCH-1:0] power_channel_outputs_out,
   output logic [NCH-1:0] inrush_current_window_out,
   output logic irq_out
);
   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   typedef struct packed
   {
      logic [NCH-1:0] cmd;
      logic [NCH-1:0] outs;
      logic [NCH-1:0] inrush;
      logic supply_low_flag;
      logic supply_high_flag;
      logic pump_fault_flag;
      logic pump_settled;
      logic fail_mode;
      sfs_pkg::sfs_evt_t irq_st;
      sfs_pkg::sfs_evt_t irq_msk;
      sfs_pkg::sfs_st_t uv_st;
      logic [31:0] rdata;
   } sfs_top_st_t;
   sfs_top_st_t st, next_st;
   logic uv_hit, cp_hit, restart_done, cp_bad;
   logic wr, rd, mapped;
   logic device_fault_summary_flag;
   assign cp_bad = !pump_valid_in;
   // ------------------------------------------------------------
   // Filters and timer
   // ------------------------------------------------------------
   sfs_filter #(.CYCLES(`SFS_UV_FILT_CYC)) u_uv (
      .clock_in(clock_in),
      .sys_rst_in(sys_rst_in),
      .level_in(supply_low_in),
      .hit_out(uv_hit)
   );
   sfs_filter #(.CYCLES(`SFS_CP_FILT_CYC)) u_cp (
      .clock_in(clock_in),
      .sys_rst_in(sys_rst_in),
      .level_in(cp_bad && st.pump_settled),
      .hit_out(cp_hit)
   );
   sfs_timer #(.CYCLES(RESTART_CYC)) u_rs (
      .clock_in(clock_in),
      .sys_rst_in(sys_rst_in),
      .run_in(st.uv_st == sfs_pkg::SFS_WAIT),
      .done_out(restart_done)
   );
   // ------------------------------------------------------------
   // Bus decode
   // ------------------------------------------------------------
   function automatic logic addr_is(input logic [11:0] a,
                                    input logic [11:0] r);
      addr_is = (a == r);
   endfunction : addr_is
   assign wr = psel_in && penable_in && pwrite_in;
   assign rd = psel_in && penable_in && !pwrite_in;
   assign mapped = addr_is(paddr_in, `SFS_A_QUICK) ||
                   addr_is(paddr_in, `SFS_A_DEVST) ||
                   addr_is(paddr_in, `SFS_A_OUTCTL) ||
                   addr_is(paddr_in, `SFS_A_MODE) ||
                   addr_is(paddr_in, `SFS_A_IRQST) ||
                   addr_is(paddr_in, `SFS_A_IRQMSK);
   assign device_fault_summary_flag = st.supply_low_flag || st.supply_high_flag ||
                st.pump_fault_flag;
   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb
   begin
      logic fault_off;
      logic [31:0] rv;
      fault_off = 1'b0;
      rv = 32'h0000_0000;
      next_st = st;
      // Pump settling is seen once at power up.
      if (pump_valid_in)
      begin
         next_st.pump_settled = 1'b1;
      end
      // Outputs follow the kept command unless a fault blocks them.
      // A short pump dip must not drop the channels; only the filter does.
      fault_off = !st.pump_settled || cp_hit ||
                  (st.uv_st != sfs_pkg::SFS_RUN);
      if (uv_hit)
      begin
         next_st.supply_low_flag = 1'b1;
         next_st.irq_st.low = 1'b1;
      end
      if (supply_high_in)
      begin
         next_st.supply_high_flag = 1'b1;
         next_st.irq_st.high = 1'b1;
      end
      if (cp_hit)
      begin
         next_st.pump_fault_flag = 1'b1;
         next_st.irq_st.pump = 1'b1;
      end
      case (st.uv_st)
         sfs_pkg::SFS_RUN:
         begin
            if (uv_hit)
            begin
               next_st.uv_st = st.fail_mode ? sfs_pkg::SFS_WAIT :
                               sfs_pkg::SFS_OFF;
               if (!st.fail_mode)
               begin
                  next_st.cmd = '0;
               end
            end
         end
         sfs_pkg::SFS_OFF:
         begin
            if (!supply_low_in && wr &&
                addr_is(paddr_in, `SFS_A_OUTCTL))
            begin
               next_st.uv_st = sfs_pkg::SFS_RUN;
            end
         end
         sfs_pkg::SFS_WAIT:
         begin
            if (restart_done && !supply_low_in)
            begin
               next_st.uv_st = sfs_pkg::SFS_RUN;
            end
         end
         default:
         begin
            next_st.uv_st = sfs_pkg::SFS_RUN;
         end
      endcase
      if (wr && addr_is(paddr_in, `SFS_A_OUTCTL))
      begin
         next_st.cmd = pwdata_in[NCH-1:0];
      end
      if (wr && addr_is(paddr_in, `SFS_A_MODE))
      begin
         next_st.fail_mode = pwdata_in[0];
      end
      if (wr && addr_is(paddr_in, `SFS_A_IRQMSK))
      begin
         next_st.irq_msk = pwdata_in[2:0];
      end
      if (wr && addr_is(paddr_in, `SFS_A_IRQST))
      begin
         // A new event in the same cycle keeps its bit set.
         next_st.irq_st = next_st.irq_st &
                          ~(pwdata_in[2:0] & ~{cp_hit,
                          supply_high_in, uv_hit});
      end
      if (rd && addr_is(paddr_in, `SFS_A_DEVST))
      begin
         if (!supply_low_in && !uv_hit)
         begin
            next_st.supply_low_flag = 1'b0;
         end
         if (!supply_high_in)
         begin
            next_st.supply_high_flag = 1'b0;
         end
      end
      if (rd && addr_is(paddr_in, `SFS_A_QUICK) && !cp_bad && !cp_hit)
      begin
         next_st.pump_fault_flag = 1'b0;
      end
      next_st.outs = fault_off ? '0 : st.cmd;
      // Inrush window opens for one cycle on each rising channel.
      next_st.inrush = next_st.outs & ~st.outs;
      if (addr_is(paddr_in, `SFS_A_QUICK))
      begin
         rv[`SFS_B_PUMP] = st.pump_fault_flag;
         rv[`SFS_B_SUM] = device_fault_summary_flag;
      end
      else if (addr_is(paddr_in, `SFS_A_DEVST))
      begin
         rv[`SFS_B_UV] = st.supply_low_flag;
         rv[`SFS_B_OV] = st.supply_high_flag;
         rv[`SFS_B_SUM] = device_fault_summary_flag;
      end
      else if (addr_is(paddr_in, `SFS_A_OUTCTL))
      begin
         rv[NCH-1:0] = st.cmd;
      end
      else if (addr_is(paddr_in, `SFS_A_MODE))
      begin
         rv[0] = st.fail_mode;
      end
      else if (addr_is(paddr_in, `SFS_A_IRQST))
      begin
         rv[2:0] = st.irq_st;
      end
      else if (addr_is(paddr_in, `SFS_A_IRQMSK))
      begin
         rv[2:0] = st.irq_msk;
      end
      next_st.rdata = (psel_in && !penable_in) ? rv : st.rdata;
   end
   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   always_ff @(posedge clock_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
      begin
         st <= '{default: '0, uv_st: sfs_pkg::SFS_RUN};
      end
      else
      begin
         st <= next_st;
      end
   end
   assign prdata_out = st.rdata;
   assign pready_out = 1'b1;
   assign pslverr_out = psel_in && penable_in && !mapped;
   assign power_channel_outputs_out = st.outs;
   assign inrush_current_window_out = st.inrush;
   assign irq_out = |(st.irq_st & st.irq_msk);
endmodule : sfs_top

/* File: test/sfs_monitor.sv */
// Purpose: Port checker for the supply fault supervisor.
// Assumes: Filters of 175 and 200 cycles on a 50 MHz clock.
// Notes: Counters saturate so that long faults stay visible.
`timescale 1ns/1ps
`include "sfs_defines.svh"
module sfs_monitor #(
   parameter int RESTART_CYC = 50,
   parameter int NCH = 5
)(
   input wire logic clock_in,
   input wire logic sys_rst_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [11:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   input wire logic [31:0] prdata_out,
   input wire logic pready_out,
   input wire logic pslverr_out,
   input wire logic supply_low_in,
   input wire logic supply_high_in,
   input wire logic pump_valid_in,
   input wire logic [NCH-1:0] power_channel_outputs_out,
   input wire logic [NCH-1:0] inrush_current_window_out,
   input wire logic irq_out
);
   logic [8:0] low_cnt;
   logic [8:0] bad_cnt;
   logic seen;
   logic wr_ctl;
   logic rd_dev;
   logic rd_quick;
   logic [NCH-1:0] pw;
   assign pw = power_channel_outputs_out;
   assign wr_ctl = psel_in & penable_in & pwrite_in &
                   (paddr_in == `SFS_A_OUTCTL);
   assign rd_dev = psel_in & !penable_in & (paddr_in == `SFS_A_DEVST);
   assign rd_quick = psel_in & !penable_in & (paddr_in == `SFS_A_QUICK);
   // The pump filter only counts once the pump has been valid.
   always_ff @(posedge clock_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
      begin
         low_cnt <= 9'h000;
         bad_cnt <= 9'h000;
         seen <= 1'b0;
      end
      else
      begin
         low_cnt <= supply_low_in ?
                    low_cnt + {8'h00, low_cnt != 9'h1FF} : 9'h000;
         bad_cnt <= (pump_valid_in | !seen) ? 9'h000 :
                    bad_cnt + {8'h00, bad_cnt != 9'h1FF};
         seen <= seen | pump_valid_in;
      end
   end
   default clocking cb @(posedge clock_in);
   endclocking
   default disable iff (sys_rst_in);
   chk_low_shut: assert property (low_cnt > 9'h0B4 |-> pw == '0)
      else $error("channels on during long supply low");
   chk_pump_shut: assert property (bad_cnt > 9'h0D2 |-> pw == '0)
      else $error("channels on during long pump fault");
   chk_pump_hold: assert property (!seen |-> pw == '0)
      else $error("channels on before pump settled");
   chk_fall_cause: assert property (|($past(pw) & ~pw) |->
      low_cnt > 9'h0A0 || bad_cnt > 9'h0B4 ||
      $past(wr_ctl) || $past(wr_ctl, 2))
      else $error("channel dropped without cause");
   chk_inrush_rise: assert property (|(pw & ~$past(pw)) |->
      ##[0:1] |inrush_current_window_out)
      else $error("no inrush window on turn on");
   chk_low_flag: assert property (rd_dev && low_cnt > 9'h0B4 |=>
      prdata_out[0] && prdata_out[7])
      else $error("supply low flag missing");
   chk_high_flag: assert property (rd_dev && supply_high_in &&
      $past(supply_high_in) |=> prdata_out[1] && prdata_out[7])
      else $error("supply high flag missing");
   chk_pump_flag: assert property (rd_quick && bad_cnt > 9'h0D2 |=>
      prdata_out[0] && prdata_out[7])
      else $error("pump flag missing");
endmodule : sfs_monitor
bind sfs_top sfs_monitor #(.RESTART_CYC(RESTART_CYC), .NCH(NCH))
   sfs_monitor_i (
   .clock_in(clock_in), .sys_rst_in(sys_rst_in), .psel_in(psel_in),
   .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
   .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
   .pslverr_out(pslverr_out), .supply_low_in(supply_low_in),
   .supply_high_in(supply_high_in), .pump_valid_in(pump_valid_in),
   .power_channel_outputs_out(power_channel_outputs_out),
   .inrush_current_window_out(inrush_current_window_out), .irq_out(irq_out));

/* File: test/sfs_mcu_model.sv */
// Purpose: Controller model that reads and writes over the register bus.
// Assumes: The slave may stretch the access phase.
// Notes: Released write data is inverted so stale values never match.
`timescale 1ns/1ps
module sfs_mcu_model (
   input wire logic clock_in,
   output logic psel_out,
   output logic penable_out,
   output logic pwrite_out,
   output logic [11:0] paddr_out,
   output logic [31:0] pwdata_out,
   input wire logic [31:0] prdata_in,
   input wire logic pready_in,
   input wire logic pslverr_in
);
   logic hang;
   initial
   begin
      hang = 1'b0;
      psel_out = 1'b0;
      penable_out = 1'b0;
      pwrite_out = 1'b0;
      paddr_out = 12'h000;
      pwdata_out = 32'h0000_0000;
   end
   task xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] q, output logic e);
      int n;
      @(posedge clock_in);
      psel_out <= 1'b1;
      pwrite_out <= w;
      paddr_out <= a;
      pwdata_out <= d;
      @(posedge clock_in);
      penable_out <= 1'b1;
      n = 0;
      do
      begin
         @(posedge clock_in);
         n++;
      end
      while (pready_in !== 1'b1 && n < 64);
      hang = pready_in !== 1'b1;
      q = prdata_in;
      e = pslverr_in;
      psel_out <= 1'b0;
      penable_out <= 1'b0;
      pwdata_out <= ~d;
   endtask : xfer
endmodule : sfs_mcu_model

/* File: test/sfs_bench.sv */
// Purpose: Self-checking bench for the supply fault supervisor.
// Assumes: Autorestart shortened to 50 cycles.
// Notes: Waits on outputs are bounded at 300 cycles.
`timescale 1ns/1ps
`include "sfs_defines.svh"
module sfs_bench;
   logic clock_in, sys_rst_in, psel, pen, pwr, pready, perr;
   logic lo, hi, pv, irq, e;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic [4:0] pw, inr;
   int failures = 0;
   int total_checks = 0;
   sfs_top #(.RESTART_CYC(50), .NCH(5)) sfs_top_i (.clock_in(clock_in),
      .sys_rst_in(sys_rst_in), .psel_in(psel), .penable_in(pen),
      .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata),
      .prdata_out(prdata), .pready_out(pready), .pslverr_out(perr),
      .supply_low_in(lo), .supply_high_in(hi), .pump_valid_in(pv),
      .power_channel_outputs_out(pw), .inrush_current_window_out(inr),
      .irq_out(irq));
   sfs_mcu_model sfs_mcu_model_i (.clock_in(clock_in), .psel_out(psel),
      .penable_out(pen), .pwrite_out(pwr), .paddr_out(paddr),
      .pwdata_out(pwdata), .prdata_in(prdata), .pready_in(pready),
      .pslverr_in(perr));
   initial
   begin
      clock_in = 1'b0;
      forever #10 clock_in = ~clock_in;
   end
   task close_out;
      $display("checks %0d mismatches %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : close_out
   always @(posedge sfs_mcu_model_i.hang)
   begin
      failures++;
      close_out;
   end
   task check(input logic [31:0] seen, input logic [31:0] want);
      total_checks++;
      if (seen !== want)
      begin
         failures++;
         $display("wrong value at %0t: saw %h want %h", $time, seen, want);
      end
   endtask : check
   task rd(input logic [11:0] a, input logic [31:0] want);
      sfs_mcu_model_i.xfer(1'b0, a, 32'h0000_0000, q, e);
      check(q, want);
   endtask : rd
   task wr(input logic [11:0] a, input logic [31:0] d);
      sfs_mcu_model_i.xfer(1'b1, a, d, q, e);
   endtask : wr
   task hold(input int n);
      repeat (n) @(posedge clock_in);
   endtask : hold
   task wait_pw(input logic [4:0] want);
      int n;
      for (n = 0; n < 300 && pw !== want; n++)
         @(posedge clock_in);
      check(pw, want);
      if (pw !== want)
         close_out;
   endtask : wait_pw
   initial
   begin
      sys_rst_in = 1'b1;
      lo = 1'b0;
      hi = 1'b0;
      pv = 1'b0;
      hold(8);
      sys_rst_in <= 1'b0;
      wr(`SFS_A_OUTCTL, 32'h0000_001F);
      hold(20);
      check(pw, 5'h00);
      pv <= 1'b1;
      wait_pw(5'h1F);
      check(inr, 5'h1F);
      $display("pump start test done");
      lo <= 1'b1;
      hold(100);
      lo <= 1'b0;
      hold(5);
      check(pw, 5'h1F);
      lo <= 1'b1;
      hold(180);
      check(pw, 5'h00);
      rd(`SFS_A_DEVST, 32'h0000_0081);
      lo <= 1'b0;
      hold(2);
      rd(`SFS_A_DEVST, 32'h0000_0081);
      rd(`SFS_A_DEVST, 32'h0000_0000);
      check(pw, 5'h00);
      wr(`SFS_A_OUTCTL, 32'h0000_001F);
      wait_pw(5'h1F);
      hi <= 1'b1;
      hold(2);
      rd(`SFS_A_DEVST, 32'h0000_0082);
      hi <= 1'b0;
      hold(2);
      rd(`SFS_A_DEVST, 32'h0000_0082);
      rd(`SFS_A_DEVST, 32'h0000_0000);
      $display("supply test done");
      pv <= 1'b0;
      hold(210);
      check(pw, 5'h00);
      rd(`SFS_A_QUICK, 32'h0000_0081);
      wr(`SFS_A_OUTCTL, 32'h0000_001F);
      pv <= 1'b1;
      wait_pw(5'h1F);
      check(inr, 5'h1F);
      rd(`SFS_A_QUICK, 32'h0000_0081);
      rd(`SFS_A_QUICK, 32'h0000_0000);
      $display("pump fault test done");
      wr(`SFS_A_MODE, 32'h0000_0001);
      lo <= 1'b1;
      hold(180);
      check(pw, 5'h00);
      lo <= 1'b0;
      hold(10);
      check(pw, 5'h00);
      wait_pw(5'h1F);
      $display("autorestart test done");
      rd(`SFS_A_IRQST, 32'h0000_0007);
      check(irq, 1'b0);
      wr(`SFS_A_IRQMSK, 32'h0000_0007);
      rd(`SFS_A_IRQMSK, 32'h0000_0007);
      check(irq, 1'b1);
      wr(`SFS_A_IRQST, 32'h0000_0007);
      rd(`SFS_A_IRQST, 32'h0000_0000);
      check(irq, 1'b0);
      wr(`SFS_A_IRQMSK, 32'h0000_0000);
      rd(12'h100, 32'h0000_0000);
      check(e, 1'b1);
      $display("register test done");
      close_out;
   end
endmodule : sfs_bench
